// ### ext_osc_regs.svh
// Register offsets, field positions, reset values and timing counts of the clock selector.
`ifndef EXT_OSC_REGS_SVH
`define EXT_OSC_REGS_SVH

`define ECR_OFFSET 4'h0
`define CSR_OFFSET 4'h4
`define ICR_OFFSET 4'h8

`define ECR_VALID_BIT 7
`define ECR_MODE_LSB 4
`define ECR_FREQ_LSB 0
`define CSR_SEL_LSB 0
`define CSR_BUSY_BIT 4
`define CSR_ACT_LSB 5
`define ICR_EN_BIT 7

`define ECR_MODE_RST 3'h0
`define ECR_FREQ_RST 3'h0
`define CSR_SEL_RST 2'h0
`define ICR_EN_RST 1'h1

`define MODE_CMOS_DIV 3'h3
`define SEL_INT 2'h0
`define SEL_EXT 2'h1
`define SEL_MULT 2'h2

`define REF_CLK_PERIOD_NS 20
`define XTAL_WAIT_NS 1000000
`define XTAL_SETTLE_EDGES 256

`endif

// ### ext_osc_pkg.sv
// Types shared by the clock selector modules.
package ext_osc_pkg;
    typedef logic [1:0] src_idx_t;
    typedef enum logic [1:0] {SW_FOLLOW, SW_DRAIN, SW_PARK} sw_state_t;
endpackage

// ### clk_switch_if.sv
// Carrier between the register side and the glitch-free source switch.
`timescale 1ns/1ps
interface clk_switch_if;
    import ext_osc_pkg::*;
    src_idx_t req_sel;
    logic [2:0] src_lvl;
    logic sw_out;
    logic busy;
    src_idx_t active;
    modport ctrl (output req_sel, output src_lvl, input sw_out, input busy, input active);
    modport mux (input req_sel, input src_lvl, output sw_out, output busy, output active);
endinterface

// ### sync_2ff.sv
// Two-flop synchroniser for pin levels.
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_ff <= '0;
            q <= '0;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule

// ### clk_glitch_free_mux.sv
// Glitch-free selector of the sampled clock sources.
`timescale 1ns/1ps
module clk_glitch_free_mux
    import ext_osc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    clk_switch_if.mux sw
);
    sw_state_t state_ff;
    sw_state_t nxt_state;
    src_idx_t cur_ff;
    src_idx_t nxt_cur;
    logic out_ff;
    logic nxt_out;

    wire cur_lvl = sw.src_lvl[cur_ff];
    wire new_lvl = sw.src_lvl[sw.req_sel];

    // The old source is left only while it is low, and the new one is joined only while it is low,
    // so every high phase on the output is a whole phase of one source.
    always_comb begin
        nxt_state = state_ff;
        nxt_cur = cur_ff;
        nxt_out = 1'b0;
        unique case (state_ff)
            SW_FOLLOW: begin
                nxt_out = cur_lvl;
                if (sw.req_sel != cur_ff) begin
                    nxt_state = SW_DRAIN;
                end
            end
            SW_DRAIN: begin
                nxt_out = cur_lvl;
                if (!cur_lvl) begin
                    nxt_out = 1'b0;
                    nxt_state = SW_PARK;
                end
            end
            SW_PARK: begin
                if (!new_lvl) begin
                    nxt_cur = sw.req_sel;
                    nxt_state = SW_FOLLOW;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= SW_FOLLOW;
            cur_ff <= 2'h0;
            out_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cur_ff <= nxt_cur;
            out_ff <= nxt_out;
        end
    end

    assign sw.sw_out = out_ff;
    assign sw.busy = (state_ff != SW_FOLLOW);
    assign sw.active = cur_ff;

    sequence seq_drain_done;
        state_ff == SW_DRAIN ##1 state_ff == SW_PARK;
    endsequence

    chk_no_runt_rise: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(out_ff) |-> $past(state_ff) != SW_PARK)
        else $error("Output rose while parked between sources.");
    chk_park_held_low: assert property (@(posedge ref_clk) disable iff (rst)
        seq_drain_done |-> !out_ff)
        else $error("Output not low after draining old source.");
    chk_join_new_low: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == SW_PARK && nxt_state == SW_FOLLOW) |-> !new_lvl ##1 cur_ff == $past(sw.req_sel))
        else $error("New source joined while high or wrong source taken.");
endmodule

// ### ext_osc_sysclk_select.sv
// External oscillator control, crystal valid detection and system clock source selection.
`timescale 1ns/1ps
`include "ext_osc_regs.svh"
module ext_osc_sysclk_select
    import ext_osc_pkg::*;
#(
    parameter int XTAL_WAIT_CYCLES = (`XTAL_WAIT_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS,
    parameter int XTAL_SETTLE_EDGES = `XTAL_SETTLE_EDGES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic int_osc_clk_in,
    input wire logic crystal_pin_in,
    input wire logic mult_clk_in,
    output logic sysclk_out,
    output logic ext_clk_periph_out,
    output logic int_osc_en,
    output logic ext_osc_en,
    output logic crystal_amp_en,
    output logic [2:0] ext_osc_mode_sel,
    output logic [2:0] ext_osc_freq_ctrl,
    output logic [1:0] sysclk_active_src
);

    if (XTAL_WAIT_CYCLES < 1 || XTAL_WAIT_CYCLES > 20'hFFFFF) begin : g_bad_wait
        $error("XTAL_WAIT_CYCLES must lie in 1 to 1048575.");
    end
    if (XTAL_SETTLE_EDGES < 1 || XTAL_SETTLE_EDGES > 16'hFFFF) begin : g_bad_edges
        $error("XTAL_SETTLE_EDGES must lie in 1 to 65535.");
    end

    localparam logic [19:0] WAIT_LAST = XTAL_WAIT_CYCLES[19:0];
    localparam logic [15:0] EDGE_LAST = XTAL_SETTLE_EDGES[15:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus slave.

    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [2:0] mode_ff;
    logic [2:0] freq_ff;
    logic [1:0] sel_ff;
    logic icr_en_ff;
    logic valid_ff;

    wire bus_req = avs_read | avs_write;
    wire bus_first = bus_req & ~ack_ff;
    wire wr_done = avs_write & ack_ff & avs_byteenable[0];
    wire hit_ecr = (avs_address == `ECR_OFFSET);
    wire hit_csr = (avs_address == `CSR_OFFSET);
    wire hit_icr = (avs_address == `ICR_OFFSET);
    wire ecr_wr = wr_done & hit_ecr;
    wire csr_wr = wr_done & hit_csr;
    wire icr_wr = wr_done & hit_icr;
    wire [2:0] wr_mode = avs_writedata[`ECR_MODE_LSB +: 3];
    wire [2:0] wr_freq = avs_writedata[`ECR_FREQ_LSB +: 3];
    wire [1:0] wr_sel = avs_writedata[`CSR_SEL_LSB +: 2];

    clk_switch_if sw ();

    wire [31:0] ecr_rd = {24'h000000, valid_ff, mode_ff, 1'b0, freq_ff};
    wire [31:0] csr_rd = {24'h000000, 1'b0, sw.active, sw.busy, 2'h0, sel_ff};
    wire [31:0] icr_rd = {24'h000000, icr_en_ff, 7'h00};
    wire [31:0] rd_mux = hit_ecr ? ecr_rd : hit_csr ? csr_rd : hit_icr ? icr_rd : 32'h00000000;

    // Every access costs one wait cycle; that fixed latency keeps read data registered.
    assign avs_waitrequest = bus_first;
    assign avs_readdata = rdata_ff;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end else begin
            ack_ff <= bus_first;
            if (bus_first && avs_read) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_ff <= `ECR_MODE_RST;
            freq_ff <= `ECR_FREQ_RST;
            sel_ff <= `CSR_SEL_RST;
            icr_en_ff <= `ICR_EN_RST;
        end else begin
            if (ecr_wr) begin
                mode_ff <= wr_mode;
                freq_ff <= wr_freq;
            end
            if (csr_wr) begin
                sel_ff <= wr_sel;
            end
            if (icr_wr) begin
                icr_en_ff <= avs_writedata[`ICR_EN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin sampling and external oscillator path.

    logic [2:0] pin_sync;
    logic ext_prev_ff;
    logic div_ff;
    logic periph_ff;

    sync_2ff #(
        .WIDTH(3)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .d({mult_clk_in, crystal_pin_in, int_osc_clk_in}),
        .q(pin_sync)
    );

    wire ext_enabled = (mode_ff[2:1] != 2'h0);
    wire is_xtal = (mode_ff[2:1] == 2'h3);
    wire is_div = (mode_ff[1:0] == 2'h3);
    wire ext_rise = ext_enabled & pin_sync[1] & ~ext_prev_ff;
    wire int_lvl = icr_en_ff & pin_sync[0];
    // RC, capacitor and CMOS modes pass their edges at once; only the crystal has a settle flag.
    wire ext_lvl = ext_enabled & (is_div ? div_ff : pin_sync[1]);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_prev_ff <= 1'b0;
            div_ff <= 1'b0;
            periph_ff <= 1'b0;
        end else begin
            ext_prev_ff <= pin_sync[1];
            if (!ext_enabled || !is_div) begin
                div_ff <= 1'b0;
            end else if (ext_rise) begin
                div_ff <= ~div_ff;
            end
            periph_ff <= ext_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Crystal valid detection.

    logic [19:0] wait_cnt_ff;
    logic [15:0] edge_cnt_ff;

    // Both the bias time and a run of real edges must pass; either alone could flag a crystal
    // that is still ringing up.
    wire xtal_restart = !is_xtal || (ecr_wr && wr_mode != mode_ff);
    wire wait_done = (wait_cnt_ff == WAIT_LAST);
    wire edges_done = (edge_cnt_ff == EDGE_LAST);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wait_cnt_ff <= 20'h00000;
            edge_cnt_ff <= 16'h0000;
            valid_ff <= 1'b0;
        end else if (xtal_restart) begin
            wait_cnt_ff <= 20'h00000;
            edge_cnt_ff <= 16'h0000;
            valid_ff <= 1'b0;
        end else begin
            if (!wait_done) begin
                wait_cnt_ff <= wait_cnt_ff + 20'h00001;
            end
            if (ext_rise && !edges_done) begin
                edge_cnt_ff <= edge_cnt_ff + 16'h0001;
            end
            if (wait_done && edges_done) begin
                valid_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // System clock source selection.

    // Only code 01 names the external source; code 11 falls back to the internal one.
    wire [1:0] req_idx = (sel_ff == `SEL_EXT) ? 2'h1 : (sel_ff == `SEL_MULT) ? 2'h2 : 2'h0;

    assign sw.req_sel = req_idx;
    assign sw.src_lvl = {pin_sync[2], ext_lvl, int_lvl};

    clk_glitch_free_mux u_switch (
        .ref_clk(ref_clk),
        .rst(rst),
        .sw(sw)
    );

    assign sysclk_out = sw.sw_out;
    assign sysclk_active_src = sw.active;
    assign ext_clk_periph_out = periph_ff;
    assign int_osc_en = icr_en_ff;
    assign ext_osc_en = ext_enabled;
    assign crystal_amp_en = is_xtal;
    assign ext_osc_mode_sel = mode_ff;
    assign ext_osc_freq_ctrl = freq_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence seq_int_select;
        csr_wr && wr_sel == `SEL_INT;
    endsequence

    chk_int_sel_now: assert property (@(posedge ref_clk) disable iff (rst)
        seq_int_select |=> sel_ff == `SEL_INT && sw.req_sel == 2'h0)
        else $error("Internal selection did not take effect at once.");
    chk_xtal_valid_set: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(valid_ff) |-> $past(is_xtal) && $past(wait_done) && $past(edges_done))
        else $error("Crystal valid set before settling.");
    chk_xtal_valid_rise: assert property (@(posedge ref_clk) disable iff (rst)
        (!xtal_restart && wait_done && edges_done) |=> valid_ff)
        else $error("Crystal valid not set after settling.");
    chk_rc_no_wait: assert property (@(posedge ref_clk) disable iff (rst)
        (mode_ff[2:1] == 2'h2 && $rose(pin_sync[1])) |=> periph_ff)
        else $error("RC or capacitor clock delayed.");
    // The select may already have moved on for one cycle before the switch starts to drain.
    chk_ext_route: assert property (@(posedge ref_clk) disable iff (rst)
        (!sw.busy && sw.active == 2'h1) |-> $past(sel_ff) == `SEL_EXT)
        else $error("External source routed without select code 01.");
    chk_periph_ext: assert property (@(posedge ref_clk) disable iff (rst)
        (sel_ff != `SEL_EXT) |=> periph_ff == $past(ext_lvl))
        else $error("External clock lost to peripherals.");
    chk_div2_mode: assert property (@(posedge ref_clk) disable iff (rst)
        (mode_ff == `MODE_CMOS_DIV && ext_rise && !ecr_wr) |=> div_ff != $past(div_ff))
        else $error("Divide-by-two stage did not toggle.");

    // Bus handshake: one wait cycle per request, read data captured from the addressed register.
    sequence seq_req_rise;
        !bus_req ##1 bus_req;
    endsequence

    sequence seq_read_taken;
        bus_first && avs_read;
    endsequence

    chk_bus_wait_first: assert property (@(posedge ref_clk) disable iff (rst)
        seq_req_rise |-> avs_waitrequest)
        else $error("New request not held off in its first cycle.");
    chk_bus_ack_pulse: assert property (@(posedge ref_clk) disable iff (rst)
        ack_ff |=> !ack_ff)
        else $error("Bus acknowledge lasted more than one cycle.");
    chk_read_capture: assert property (@(posedge ref_clk) disable iff (rst)
        seq_read_taken |=> avs_readdata == $past(rd_mux))
        else $error("Read data not captured from the addressed register.");
    chk_read_unmapped: assert property (@(posedge ref_clk) disable iff (rst)
        (seq_read_taken and (!hit_ecr && !hit_csr && !hit_icr)) |=> avs_readdata == 32'h00000000)
        else $error("Unmapped read returned non-zero data.");
    chk_byte_masked: assert property (@(posedge ref_clk) disable iff (rst)
        (avs_write && ack_ff && !avs_byteenable[0]) |=> $stable(mode_ff) && $stable(freq_ff) && $stable(sel_ff))
        else $error("Write with low byte disabled changed a register.");

    // Register fields take exactly what software wrote.
    chk_mode_write: assert property (@(posedge ref_clk) disable iff (rst)
        ecr_wr |=> mode_ff == $past(wr_mode) && freq_ff == $past(wr_freq))
        else $error("Mode or frequency field not updated by write.");
    chk_sel_write: assert property (@(posedge ref_clk) disable iff (rst)
        csr_wr |=> sel_ff == $past(wr_sel))
        else $error("Select field not updated by write.");
    chk_icr_write: assert property (@(posedge ref_clk) disable iff (rst)
        icr_wr |=> icr_en_ff == $past(avs_writedata[`ICR_EN_BIT]))
        else $error("Internal enable not updated by write.");
    chk_sel_code3_int: assert property (@(posedge ref_clk) disable iff (rst)
        (sel_ff == 2'h3) |-> sw.req_sel == 2'h0)
        else $error("Select code 11 did not fall back to internal source.");
    chk_sel_ext_code: assert property (@(posedge ref_clk) disable iff (rst)
        (sw.req_sel == 2'h1) |-> sel_ff == `SEL_EXT)
        else $error("External source requested without code 01.");

    // Crystal valid follows the settle counters and drops whenever crystal mode is left.
    chk_valid_only_xtal: assert property (@(posedge ref_clk) disable iff (rst)
        !is_xtal |=> !valid_ff)
        else $error("Crystal valid set outside crystal mode.");
    chk_valid_counts_done: assert property (@(posedge ref_clk) disable iff (rst)
        valid_ff |-> wait_done && edges_done)
        else $error("Crystal valid high with settle counts incomplete.");
    chk_restart_clears: assert property (@(posedge ref_clk) disable iff (rst)
        xtal_restart |=> wait_cnt_ff == 20'h00000 && edge_cnt_ff == 16'h0000 && !valid_ff)
        else $error("Crystal restart did not clear settle state.");

    // External path, divider, internal source gating and switch start.
    chk_ext_off_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        !ext_enabled |=> !periph_ff && !div_ff)
        else $error("External clock active while oscillator off.");
    chk_div_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (is_div && ext_enabled && !ext_rise) |=> $stable(div_ff))
        else $error("Divide-by-two stage toggled without a rising edge.");
    chk_mode_div_output: assert property (@(posedge ref_clk) disable iff (rst)
        (mode_ff == `MODE_CMOS_DIV) |-> ext_lvl == div_ff)
        else $error("Divided CMOS mode not taken from the divider.");
    chk_int_off_low: assert property (@(posedge ref_clk) disable iff (rst)
        !icr_en_ff |-> !sw.src_lvl[0])
        else $error("Disabled internal source still toggling.");
    chk_busy_on_change: assert property (@(posedge ref_clk) disable iff (rst)
        (!sw.busy && sw.req_sel != sw.active) |=> sw.busy)
        else $error("Switch did not start after a select change.");
endmodule

// ### osc_source_model.sv
// Behavioural model of an oscillator source seen as a sampled pin level.
`timescale 1ns/1ps
module osc_source_model #(
    parameter int HALF = 5,
    parameter int START = 0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic run,
    output logic lvl
);
    int cnt = 0;

    // A stopped source holds its pin low, as grounded crystal pins do, so stale highs never leak through.
    // A crystal gives no edges until START cycles after it is enabled, which models its slow bias-up.
    always @(posedge ref_clk) begin
        if (rst || !run) begin
            lvl <= 1'b0;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
            if (cnt >= START && (cnt - START) % HALF == 0) begin
                lvl <= ~lvl;
            end
        end
    end
endmodule

// ### ext_osc_sysclk_select_tb.sv
// Self-checking testbench of the oscillator control and system clock selector.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module ext_osc_sysclk_select_tb;
    logic ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, mult_run = 1'b1;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, int_osc_clk_in, crystal_pin_in, mult_clk_in, sysclk_out, ext_clk_periph_out;
    logic int_osc_en, ext_osc_en, crystal_amp_en;
    logic [2:0] ext_osc_mode_sel, ext_osc_freq_ctrl;
    logic [1:0] sysclk_active_src;
    logic [4:0] pv = 5'h00;
    int bad_count = 0, checked = 0, cyc = 0, runt = 0, hr = 0, n, t0;
    int rise[5] = '{default: 0};
    wire [4:0] lv = {ext_clk_periph_out, mult_clk_in, int_osc_clk_in, crystal_pin_in, sysclk_out};

    always #10 ref_clk = ~ref_clk;

    ext_osc_sysclk_select #(.XTAL_WAIT_CYCLES(100), .XTAL_SETTLE_EDGES(4)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .int_osc_clk_in(int_osc_clk_in),
        .crystal_pin_in(crystal_pin_in), .mult_clk_in(mult_clk_in), .sysclk_out(sysclk_out),
        .ext_clk_periph_out(ext_clk_periph_out), .int_osc_en(int_osc_en), .ext_osc_en(ext_osc_en),
        .crystal_amp_en(crystal_amp_en), .ext_osc_mode_sel(ext_osc_mode_sel),
        .ext_osc_freq_ctrl(ext_osc_freq_ctrl), .sysclk_active_src(sysclk_active_src));
    osc_source_model #(.HALF(4), .START(30)) u_xtal (.ref_clk(ref_clk), .rst(rst), .run(ext_osc_en),
        .lvl(crystal_pin_in));
    osc_source_model u_int (.ref_clk(ref_clk), .rst(rst), .run(int_osc_en), .lvl(int_osc_clk_in));
    osc_source_model #(.HALF(3)) u_mult (.ref_clk(ref_clk), .rst(rst), .run(mult_run), .lvl(mult_clk_in));

    ////////////////////////////////////////////////////////////////////////////////
    // Edge counters; a high phase of sysclk shorter than the shortest source phase is a runt.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (!rst) begin
            pv <= lv;
            for (int i = 0; i < 5; i++) rise[i] <= rise[i] + int'(lv[i] & ~pv[i]);
            hr <= sysclk_out ? hr + 1 : 0;
            if (pv[0] && !sysclk_out && hr < 3) runt <= runt + 1;
        end
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
        `CHK(n < 20, 1'b1)
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task rdchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    // Rising edges of signal a, scaled by k, must match those of signal b within two.
    task meas(input int a, input int b, input int k);
        int sa, sb;
        sa = rise[a];
        sb = rise[b];
        repeat (200) @(posedge ref_clk);
        `CHK((k * (rise[a] - sa) - (rise[b] - sb)) inside {[-2:2]}, 1'b1)
    endtask

    task wait_src(input logic [1:0] e);
        int i;
        i = 0;
        do begin bus(1'b0, 4'h4, 32'h0); i++; end while ((rd[4] !== 1'b0 || rd[6:5] !== e) && i < 60);
        `CHK(rd[6:5], e)
        `CHK(sysclk_active_src, e)
    endtask

    task tdone(input string s);
        $display("test %s done", s);
    endtask

    task end_sim;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        rdchk(4'h0, 32'h0);
        rdchk(4'h4, 32'h0);
        rdchk(4'h8, 32'h80);
        `CHK({int_osc_en, ext_osc_en, sysclk_active_src}, 4'h8)
        bus(1'b1, 4'hC, 32'hFF);
        rdchk(4'hC, 32'h0);
        avs_byteenable <= 4'hE;
        bus(1'b1, 4'h0, 32'hFF);
        avs_byteenable <= 4'hF;
        rdchk(4'h0, 32'h0);
        bus(1'b1, 4'h0, 32'hFF);
        rdchk(4'h0, 32'h77);
        tdone("reset_map");
        for (int m = 0; m < 8; m++) begin
            bus(1'b1, 4'h0, 32'(m << 4));
            repeat (2) @(posedge ref_clk);
            `CHK(ext_osc_mode_sel, 3'(m))
            `CHK({ext_osc_en, crystal_amp_en}, {m[2:1] != 2'h0, m[2:1] == 2'h3})
        end
        tdone("modes");
        bus(1'b1, 4'h0, 32'h0);
        repeat (20) @(posedge ref_clk);
        bus(1'b1, 4'h0, 32'h67);
        t0 = cyc;
        rdchk(4'h0, 32'h67);
        i = 0;
        do begin bus(1'b0, 4'h0, 32'h0); i++; end while (rd[7] !== 1'b1 && i < 100);
        `CHK(cyc - t0 >= 100, 1'b1)
        `CHK(rd[7:0], 8'hE7)
        bus(1'b1, 4'h0, 32'h60);
        rdchk(4'h0, 32'hE0);
        `CHK(ext_osc_freq_ctrl, 3'h0)
        tdone("crystal");
        t0 = rise[1];
        repeat (20) @(posedge ref_clk);
        `CHK(rise[1] > t0, 1'b1)
        bus(1'b1, 4'h4, 32'h1);
        wait_src(2'h1);
        meas(0, 1, 1);
        bus(1'b1, 4'h4, 32'h2);
        wait_src(2'h2);
        meas(0, 3, 1);
        bus(1'b1, 4'h4, 32'h3);
        wait_src(2'h0);
        meas(4, 1, 1);
        meas(0, 2, 1);
        mult_run <= 1'b0;
        bus(1'b1, 4'h4, 32'h2);
        repeat (10) @(posedge ref_clk);
        t0 = rise[0];
        repeat (30) @(posedge ref_clk);
        `CHK(rise[0] - t0, 0)
        mult_run <= 1'b1;
        bus(1'b1, 4'h4, 32'h2);
        wait_src(2'h2);
        bus(1'b1, 4'h8, 32'h0);
        rdchk(4'h8, 32'h0);
        `CHK(int_osc_en, 1'b0)
        bus(1'b1, 4'h8, 32'h80);
        bus(1'b1, 4'h4, 32'h0);
        wait_src(2'h0);
        meas(0, 2, 1);
        tdone("switch");
        bus(1'b1, 4'h0, 32'h30);
        meas(4, 1, 2);
        bus(1'b1, 4'h0, 32'h40);
        meas(4, 1, 1);
        `CHK(runt, 0)
        tdone("divider");
        end_sim();
    end
endmodule
